// *** hdl/lprt_top.sv ***
// Low power real time counter with APB register access.
// Assumes a 20 MHz system clock and a reference clock pin far slower.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module lprt_top (
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          ref_clk_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [lprt_pkg::ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]                   pwdata_i,
  output logic      [31:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               pslverr_o,
  input  wire logic                          match_ack_i,
  input  wire logic                          wrap_ack_i,
  output logic                               match_irq_o,
  output logic      [1:0]                    match_irq_level_o,
  output logic                               wrap_irq_o,
  output logic      [1:0]                    wrap_irq_level_o,
  output logic                               match_event_o,
  output logic                               wrap_event_o
);
  import lprt_pkg::*;

  logic [5:0]         idx;
  logic               addr_ok;
  logic               setup_ph;
  logic               access_ph;
  logic               wr_acc;
  logic               rd_acc;
  logic [7:0]         wbyte;
  logic [7:0]         rd_byte;
  logic [31:0]        prdata_r;
  logic               pslverr_r;

  logic [2:0]         presc_act_r;
  logic [2:0]         presc_pend_r;
  logic [COUNT_W-1:0] count_value_r;
  logic [COUNT_W-1:0] count_pend_r;
  logic [COUNT_W-1:0] top_value_r;
  logic [COUNT_W-1:0] top_pend_r;
  logic [COUNT_W-1:0] match_act_r;
  logic [COUNT_W-1:0] match_pend_r;
  logic [7:0]         latch_r;
  logic [1:0]         match_irq_level_r;
  logic [1:0]         wrap_irq_level_r;
  logic               match_flag_r;
  logic               wrap_flag_r;

  lprt_sync_e         sync_state_r;
  lprt_sync_e         sync_state_nxt;
  logic [1:0]         sync_left_r;
  logic [3:0]         pend_mask_r;
  logic [3:0]         new_pend;
  logic               sync_apply;
  logic               domain_sync_pending;

  logic               ref_tick;
  logic               count_tick;
  logic               wrap_hit;
  logic               match_hit;

  // True for every index that holds a register
  function automatic logic idx_mapped(input logic [5:0] i);
    case (i)
      IDX_PRESCALE_CONTROL, IDX_SYNC_STATE, IDX_IRQ_LEVEL_CONTROL, IDX_IRQ_FLAG_REG,
      IDX_BYTE_LATCH, IDX_COUNT_LOW, IDX_COUNT_HIGH_BYTE, IDX_TOP_LOW, IDX_TOP_HIGH,
      IDX_MATCH_LOW, IDX_MATCH_HIGH: idx_mapped = 1'b1;
      default:                       idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // APB decode: word aligned, mapped index only
  assign idx       = paddr_i[7:2];
  assign addr_ok   = (paddr_i[1:0] == 2'b00) && idx_mapped(idx);
  assign setup_ph  = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign wr_acc    = access_ph && pwrite_i && addr_ok;
  assign rd_acc    = access_ph && !pwrite_i && addr_ok;
  assign wbyte     = pwdata_i[7:0];
  assign pready_o  = 1'b1;  // Zero wait states

  // Read byte mux; reserved bits are zero
  always_comb begin
    case (idx)
      IDX_PRESCALE_CONTROL:  rd_byte = {5'h00, presc_pend_r};
      IDX_SYNC_STATE:        rd_byte = {7'h00, domain_sync_pending};
      IDX_IRQ_LEVEL_CONTROL: rd_byte = {4'h0, match_irq_level_r, wrap_irq_level_r};
      IDX_IRQ_FLAG_REG:      rd_byte = {6'h00, match_flag_r, wrap_flag_r};
      IDX_BYTE_LATCH:        rd_byte = latch_r;
      IDX_COUNT_LOW:         rd_byte = count_value_r[7:0];
      IDX_TOP_LOW:           rd_byte = top_value_r[7:0];
      IDX_MATCH_LOW:         rd_byte = match_act_r[7:0];
      IDX_COUNT_HIGH_BYTE,
      IDX_TOP_HIGH,
      IDX_MATCH_HIGH:        rd_byte = latch_r;
      default:               rd_byte = 8'h00;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r  <= (addr_ok && !pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_r <= !addr_ok;
    end else if (!psel_i) begin
      pslverr_r <= 1'b0;
    end
  end

  assign prdata_o  = prdata_r;
  assign pslverr_o = pslverr_r && access_ph;

  // Byte latch: low writes store, low reads grab the high byte
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      latch_r <= RST_LATCH;
    end else if (wr_acc && (idx == IDX_BYTE_LATCH || idx == IDX_COUNT_LOW ||
                            idx == IDX_TOP_LOW || idx == IDX_MATCH_LOW)) begin
      latch_r <= wbyte;
    end else if (rd_acc) begin
      case (idx)
        IDX_COUNT_LOW: latch_r <= count_value_r[15:8];
        IDX_TOP_LOW:   latch_r <= top_value_r[15:8];
        IDX_MATCH_LOW: latch_r <= match_act_r[15:8];
        default:       latch_r <= latch_r;
      endcase
    end
  end

  // Interrupt level register, takes effect at once
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      match_irq_level_r <= RST_LEVEL;
      wrap_irq_level_r  <= RST_LEVEL;
    end else if (wr_acc && idx == IDX_IRQ_LEVEL_CONTROL) begin
      match_irq_level_r <= wbyte[MATCH_LVL_LSB +: 2];
      wrap_irq_level_r  <= wbyte[WRAP_LVL_LSB +: 2];
    end
  end

  // Writes that must cross before they act
  always_comb begin
    new_pend             = 4'h0;
    new_pend[PEND_PRESC] = wr_acc && (idx == IDX_PRESCALE_CONTROL);
    new_pend[PEND_COUNT] = wr_acc && (idx == IDX_COUNT_HIGH_BYTE);
    new_pend[PEND_MATCH] = wr_acc && (idx == IDX_MATCH_HIGH);
    new_pend[PEND_TOP]   = wr_acc && (idx == IDX_TOP_HIGH);
  end

  // Pending values wait in shadow registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      presc_pend_r <= RST_PRESC;
      count_pend_r <= RST_COUNT;
      match_pend_r <= RST_MATCH;
      top_pend_r   <= RST_TOP;
    end else begin
      if (new_pend[PEND_PRESC]) presc_pend_r <= wbyte[PRESC_LSB +: 3];
      if (new_pend[PEND_COUNT]) count_pend_r <= {wbyte, latch_r};
      if (new_pend[PEND_MATCH]) match_pend_r <= {wbyte, latch_r};
      if (new_pend[PEND_TOP])   top_pend_r   <= {wbyte, latch_r};
    end
  end

  // Crossing engine: new writes restart a two reference cycle wait
  assign sync_apply = (sync_state_r == SYNC_WAIT) && ref_tick &&
                      (sync_left_r == 2'h1) && (new_pend == 4'h0);

  always_comb begin
    case (sync_state_r)
      SYNC_IDLE: sync_state_nxt = (new_pend != 4'h0) ? SYNC_WAIT : SYNC_IDLE;
      SYNC_WAIT: sync_state_nxt = sync_apply ? SYNC_IDLE : SYNC_WAIT;
      default:   sync_state_nxt = SYNC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync_state_r <= SYNC_IDLE;
      sync_left_r  <= 2'h0;
      pend_mask_r  <= 4'h0;
    end else begin
      sync_state_r <= sync_state_nxt;
      if (new_pend != 4'h0) begin
        sync_left_r <= SYNC_REF_CYCLES;
        pend_mask_r <= pend_mask_r | new_pend;
      end else if (sync_apply) begin
        sync_left_r <= 2'h0;
        pend_mask_r <= 4'h0;
      end else if (ref_tick && sync_left_r != 2'h0) begin
        sync_left_r <= sync_left_r - 2'h1;
      end
    end
  end

  // Busy while count, prescale or match writes are in flight
  assign domain_sync_pending = pend_mask_r[PEND_PRESC] | pend_mask_r[PEND_COUNT] |
                               pend_mask_r[PEND_MATCH];

  // Active settings on the counter side
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      presc_act_r <= RST_PRESC;
      match_act_r <= RST_MATCH;
      top_value_r <= RST_TOP;
    end else if (sync_apply) begin
      if (pend_mask_r[PEND_PRESC]) presc_act_r <= presc_pend_r;
      if (pend_mask_r[PEND_MATCH]) match_act_r <= match_pend_r;
      if (pend_mask_r[PEND_TOP])   top_value_r <= top_pend_r;
    end
  end

  lprt_prescaler #(
    .DIV_W (10)
  ) u_prescaler (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .ref_clk_i    (ref_clk_i),
    .presc_sel_i  (presc_act_r),
    .ref_tick_o   (ref_tick),
    .count_tick_o (count_tick)
  );

  // Compare conditions, one-cycle hits on each prescaled edge
  assign wrap_hit  = count_tick && (count_value_r == top_value_r);
  assign match_hit = count_tick && (count_value_r == match_act_r) &&
                     (match_act_r <= top_value_r);

  // Counter: crossed write wins, else step or clear at top
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_value_r <= RST_COUNT;
    end else if (sync_apply && pend_mask_r[PEND_COUNT]) begin
      count_value_r <= count_pend_r;
    end else if (wrap_hit) begin
      count_value_r <= '0;
    end else if (count_tick) begin
      count_value_r <= count_value_r + COUNT_W'(1);
    end
  end

  // Flags: a set in the clear cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      match_flag_r <= 1'b0;
      wrap_flag_r  <= 1'b0;
    end else begin
      match_flag_r <= match_hit |
                      (match_flag_r & ~match_ack_i &
                       ~(wr_acc && idx == IDX_IRQ_FLAG_REG && wbyte[MATCH_FLAG_BIT]));
      wrap_flag_r  <= wrap_hit |
                      (wrap_flag_r & ~wrap_ack_i &
                       ~(wr_acc && idx == IDX_IRQ_FLAG_REG && wbyte[WRAP_FLAG_BIT]));
    end
  end

  // Requests while enabled and flagged
  assign match_irq_o       = match_flag_r && (match_irq_level_r != 2'h0);
  assign wrap_irq_o        = wrap_flag_r && (wrap_irq_level_r != 2'h0);
  assign match_irq_level_o = match_irq_level_r;
  assign wrap_irq_level_o  = wrap_irq_level_r;

  // Event outputs, thinned for small top values
  lprt_evt_thin u_match_evt (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .hit_i       (match_hit),
    .top_value_i (top_value_r),
    .event_o     (match_event_o)
  );

  lprt_evt_thin u_wrap_evt (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .hit_i       (wrap_hit),
    .top_value_i (top_value_r),
    .event_o     (wrap_event_o)
  );

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // Indices of the count halves, declared before the sequences read them
  logic [5:0] idx_count_high;
  logic [5:0] idx_count_low;
  assign idx_count_high = IDX_COUNT_HIGH_BYTE;
  assign idx_count_low  = IDX_COUNT_LOW;

  sequence s_count_high_write;
    psel_i && penable_i && pwrite_i && (paddr_i == {idx_count_high, 2'b00});
  endsequence

  sequence s_count_low_read;
    psel_i && penable_i && !pwrite_i && (paddr_i == {idx_count_low, 2'b00});
  endsequence

  a_wrap_clears_count: assert property (wrap_hit && !sync_apply |=> count_value_r == '0)
    else $error("count not cleared at top");
  a_count_steps_one: assert property (count_tick && !wrap_hit && !sync_apply
                                      |=> count_value_r == $past(count_value_r) + COUNT_W'(1))
    else $error("count did not step by one");
  a_off_no_tick: assert property (presc_act_r == PRESC_OFF && $past(presc_act_r) == PRESC_OFF
                                  |-> !count_tick)
    else $error("tick while prescaler off");
  a_match_flag_set: assert property (match_hit |=> match_flag_r)
    else $error("match flag not set");
  a_wrap_flag_set: assert property (wrap_hit |=> wrap_flag_r ##0 wrap_irq_o == (wrap_irq_level_r != 2'h0))
    else $error("wrap flag not set");
  a_flag_w1c: assert property (wr_acc && idx == IDX_IRQ_FLAG_REG && wbyte[WRAP_FLAG_BIT] && !wrap_hit
                               |=> !wrap_flag_r)
    else $error("write one did not clear wrap flag");
  a_ack_clears: assert property (match_ack_i && !match_hit |=> !match_flag_r)
    else $error("ack did not clear match flag");
  a_busy_after_write: assert property (s_count_high_write |=> domain_sync_pending [*2])
    else $error("busy not raised after count write");
  a_low_read_latch: assert property (s_count_low_read |=> latch_r == $past(count_value_r[15:8]))
    else $error("high byte not latched on low read");
  a_match_above_top: assert property ($past(match_act_r > top_value_r)
                                      |-> !match_event_o && !$rose(match_flag_r))
    else $error("match reported with match above top");

endmodule : lprt_top
`default_nettype wire

// *** hdl/lprt_pkg.sv ***
// Constants, field layout and enumerations of the low power real time counter.
// Assumes one system clock and a slow reference clock that arrives as a pin.
package lprt_pkg;

  localparam int          COUNT_W          = 16;
  localparam int          ADDR_W           = 8;
  localparam int          SYS_CLK_HZ       = 20_000_000;
  localparam int          REF_HZ_FAST      = 32_768;
  localparam int          REF_HZ_SLOW      = 1_024;

  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_PRESCALE_CONTROL  = 6'h00;
  localparam logic [5:0]  IDX_SYNC_STATE        = 6'h01;
  localparam logic [5:0]  IDX_IRQ_LEVEL_CONTROL = 6'h02;
  localparam logic [5:0]  IDX_IRQ_FLAG_REG      = 6'h03;
  localparam logic [5:0]  IDX_BYTE_LATCH        = 6'h04;
  localparam logic [5:0]  IDX_COUNT_LOW         = 6'h08;
  localparam logic [5:0]  IDX_COUNT_HIGH_BYTE   = 6'h09;
  localparam logic [5:0]  IDX_TOP_LOW           = 6'h0A;
  localparam logic [5:0]  IDX_TOP_HIGH          = 6'h0B;
  localparam logic [5:0]  IDX_MATCH_LOW         = 6'h0C;
  localparam logic [5:0]  IDX_MATCH_HIGH        = 6'h0D;

  // Field positions
  localparam int          PRESC_LSB        = 0;
  localparam int          SYNC_BUSY_BIT    = 0;
  localparam int          WRAP_LVL_LSB     = 0;
  localparam int          MATCH_LVL_LSB    = 2;
  localparam int          WRAP_FLAG_BIT    = 0;
  localparam int          MATCH_FLAG_BIT   = 1;

  // Pending-write mask bits of the crossing engine
  localparam int          PEND_PRESC       = 0;
  localparam int          PEND_COUNT       = 1;
  localparam int          PEND_MATCH       = 2;
  localparam int          PEND_TOP         = 3;

  // Reset values
  localparam logic [2:0]  RST_PRESC        = 3'h0;
  localparam logic [1:0]  RST_LEVEL        = 2'h0;
  localparam logic [15:0] RST_COUNT        = 16'h0000;
  localparam logic [15:0] RST_TOP          = 16'hFFFF;
  localparam logic [15:0] RST_MATCH        = 16'h0000;
  localparam logic [7:0]  RST_LATCH        = 8'h00;

  // Timing counts
  localparam logic [1:0]  SYNC_REF_CYCLES  = 2'h2;
  localparam logic [1:0]  EVT_GAP_TOP0     = 2'h3;
  localparam logic [1:0]  EVT_GAP_TOP1     = 2'h2;
  localparam logic [1:0]  EVT_GAP_NORMAL   = 2'h1;

  typedef enum logic [2:0] {
    PRESC_OFF     = 3'b000,
    PRESC_DIV1    = 3'b001,
    PRESC_DIV2    = 3'b010,
    PRESC_DIV8    = 3'b011,
    PRESC_DIV16   = 3'b100,
    PRESC_DIV64   = 3'b101,
    PRESC_DIV256  = 3'b110,
    PRESC_DIV1024 = 3'b111
  } lprt_presc_e;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_WAIT = 2'b01
  } lprt_sync_e;

endpackage : lprt_pkg

// *** hdl/lprt_prescaler.sv ***
// Reference clock sampler and programmable divider.
// Assumes the reference pin is far slower than the system clock.
`timescale 1ns/1ns
`default_nettype none
module lprt_prescaler
  import lprt_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       ref_clk_i,
  input  wire logic [2:0] presc_sel_i,
  output logic            ref_tick_o,
  output logic            count_tick_o
);
  logic             sync1_r;
  logic             sync2_r;
  logic             prev_r;
  logic             ref_tick_r;
  logic             count_tick_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] limit;

  // Division factor minus one for each code
  function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] sel);
    case (sel)
      PRESC_DIV2:    div_limit = DIV_W'(1);
      PRESC_DIV8:    div_limit = DIV_W'(7);
      PRESC_DIV16:   div_limit = DIV_W'(15);
      PRESC_DIV64:   div_limit = DIV_W'(63);
      PRESC_DIV256:  div_limit = DIV_W'(255);
      PRESC_DIV1024: div_limit = DIV_W'(1023);
      default:       div_limit = DIV_W'(0);
    endcase
  endfunction : div_limit

  assign limit = div_limit(presc_sel_i);

  // Two-stage sampler and rising edge detect
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      prev_r     <= 1'b0;
      ref_tick_r <= 1'b0;
    end else begin
      sync1_r    <= ref_clk_i;
      sync2_r    <= sync1_r;
      prev_r     <= sync2_r;
      ref_tick_r <= sync2_r & ~prev_r;
    end
  end

  // Divider; code off clears it and stops ticks
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_r        <= '0;
      count_tick_r <= 1'b0;
    end else begin
      count_tick_r <= ref_tick_r && (presc_sel_i != PRESC_OFF) && (div_r >= limit);
      if (presc_sel_i == PRESC_OFF) begin
        div_r <= '0;
      end else if (ref_tick_r) begin
        div_r <= (div_r >= limit) ? '0 : div_r + DIV_W'(1);
      end
    end
  end

  assign ref_tick_o   = ref_tick_r;
  assign count_tick_o = count_tick_r;

endmodule : lprt_prescaler
`default_nettype wire

// *** hdl/lprt_evt_thin.sv ***
// Event thinner: passes one hit in three, two or one depending on top value.
// Assumes hit pulses last one cycle.
`timescale 1ns/1ns
`default_nettype none
module lprt_evt_thin
  import lprt_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire logic               hit_i,
  input  wire logic [COUNT_W-1:0] top_value_i,
  output logic                    event_o
);
  logic [1:0] gap_r;
  logic [1:0] gap_lim;
  logic       event_r;

  // Spacing between emitted events
  always_comb begin
    if (top_value_i == '0) begin
      gap_lim = EVT_GAP_TOP0;
    end else if (top_value_i == COUNT_W'(1)) begin
      gap_lim = EVT_GAP_TOP1;
    end else begin
      gap_lim = EVT_GAP_NORMAL;
    end
  end

  // Emit on the first hit of each group
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gap_r   <= 2'h0;
      event_r <= 1'b0;
    end else begin
      event_r <= hit_i && (gap_r == 2'h0);
      if (hit_i) begin
        gap_r <= (gap_r + 2'h1 >= gap_lim) ? 2'h0 : gap_r + 2'h1;
      end else if (gap_r >= gap_lim) begin
        gap_r <= 2'h0;
      end
    end
  end

  assign event_o = event_r;

endmodule : lprt_evt_thin
`default_nettype wire

// *** sim/tb_low_power_real_time_counter.sv ***
// Self-checking bench for the low power real time counter over APB.
// Assumes the bench alone drives the APB port, the acks and the reference pin.
`timescale 1ns/1ns
`default_nettype none
module tb_low_power_real_time_counter;
  import lprt_pkg::*;
  logic        sys_clk_i   = 1'b0;
  logic        reset_i     = 1'b1;
  logic        ref_clk_i   = 1'b0;
  logic        psel_i      = 1'b0;
  logic        penable_i   = 1'b0;
  logic        pwrite_i    = 1'b0;
  logic [7:0]  paddr_i     = 8'h00;
  logic [31:0] pwdata_i    = 32'h0;
  logic        match_ack_i = 1'b0;
  logic        wrap_ack_i  = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, match_irq_o, wrap_irq_o, match_event_o, wrap_event_o;
  logic [1:0]  match_irq_level_o, wrap_irq_level_o;
  int          miscompares, total_checks;

  lprt_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .ref_clk_i(ref_clk_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .match_ack_i(match_ack_i),
    .wrap_ack_i(wrap_ack_i), .match_irq_o(match_irq_o), .match_irq_level_o(match_irq_level_o),
    .wrap_irq_o(wrap_irq_o), .wrap_irq_level_o(wrap_irq_level_o), .match_event_o(match_event_o),
    .wrap_event_o(wrap_event_o));

  // 20 MHz system clock
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // Reference pin, 16 system cycles a period, far slower than the bus
  initial begin
    forever begin
      repeat (8) @(posedge sys_clk_i);
      ref_clk_i <= ~ref_clk_i;
    end
  end

  task complete_run;
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic wr, input logic [7:0] ad, input logic [7:0] wd, output logic [31:0] rd,
           output logic er);
    int n;
    @(posedge sys_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= ad;
    pwdata_i  <= {24'h0, wd};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) begin
      miscompares++;
      complete_run();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, {idx, 2'b00}, d, rd, er);
  endtask : wr

  task rdchk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, {idx, 2'b00}, 8'h00, rd, er);
    check(rd, exp);
  endtask : rdchk

  // Poll a register until the masked bits equal want, bounded
  task wait_bits(input logic [5:0] idx, input logic [7:0] mask, input logic [7:0] want);
    logic [31:0] rd;
    logic        er;
    int          n;
    n = 0;
    do begin
      apb(1'b0, {idx, 2'b00}, 8'h00, rd, er);
      n++;
    end while ((rd[7:0] & mask) !== want && n < 300);
    if ((rd[7:0] & mask) !== want) begin
      miscompares++;
      complete_run();
    end
  endtask : wait_bits

  // Reset values, reserved bits and an unmapped index
  task scen_reset;
    logic [31:0] rd;
    logic        er;
    rdchk(IDX_PRESCALE_CONTROL, 32'h0);
    rdchk(IDX_SYNC_STATE, 32'h0);
    rdchk(IDX_IRQ_LEVEL_CONTROL, 32'h0);
    rdchk(IDX_IRQ_FLAG_REG, 32'h0);
    apb(1'b0, 8'h14, 8'h00, rd, er);
    check({31'h0, er}, 32'h1);
  endtask : scen_reset

  // Every prescale code is accepted and read back
  task scen_prescale;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PRESCALE_CONTROL, 8'(c));
      rdchk(IDX_PRESCALE_CONTROL, 32'(c));
    end
    wr(IDX_PRESCALE_CONTROL, 8'h00);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
  endtask : scen_prescale

  // Top 5, match 3: both flags and both requests rise, count stays within top
  task scen_wrap_match;
    logic [31:0] rd;
    logic        er;
    wr(IDX_IRQ_LEVEL_CONTROL, 8'h05);
    @(negedge sys_clk_i);
    check({30'h0, match_irq_level_o}, 32'h1);
    check({30'h0, wrap_irq_level_o}, 32'h1);
    wr(IDX_TOP_LOW, 8'h05);
    wr(IDX_TOP_HIGH, 8'h00);
    wr(IDX_MATCH_LOW, 8'h03);
    wr(IDX_MATCH_HIGH, 8'h00);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_COUNT_HIGH_BYTE, 8'h00);
    wr(IDX_PRESCALE_CONTROL, 8'h01);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    wait_bits(IDX_IRQ_FLAG_REG, 8'h03, 8'h03);
    check({31'h0, match_irq_o}, 32'h1);
    check({31'h0, wrap_irq_o}, 32'h1);
    apb(1'b0, {IDX_COUNT_LOW, 2'b00}, 8'h00, rd, er);
    check({31'h0, rd[7:0] <= 8'h05}, 32'h1);
  endtask : scen_wrap_match

  // Stopped counter: zero write keeps, each ack clears its flag
  task scen_flags;
    wr(IDX_PRESCALE_CONTROL, 8'h00);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    wr(IDX_IRQ_FLAG_REG, 8'h00);
    rdchk(IDX_IRQ_FLAG_REG, 32'h3);
    @(posedge sys_clk_i);
    match_ack_i <= 1'b1;
    @(posedge sys_clk_i);
    match_ack_i <= 1'b0;
    rdchk(IDX_IRQ_FLAG_REG, 32'h1);
    check({31'h0, match_irq_o}, 32'h0);
    @(posedge sys_clk_i);
    wrap_ack_i <= 1'b1;
    @(posedge sys_clk_i);
    wrap_ack_i <= 1'b0;
    rdchk(IDX_IRQ_FLAG_REG, 32'h0);
    check({31'h0, wrap_irq_o}, 32'h0);
  endtask : scen_flags

  // Sixteen-bit count through the byte latch, busy during crossing
  task scen_latch;
    wr(IDX_COUNT_LOW, 8'h34);
    wr(IDX_COUNT_HIGH_BYTE, 8'h12);
    rdchk(IDX_SYNC_STATE, 32'h1);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    rdchk(IDX_COUNT_LOW, 32'h34);
    rdchk(IDX_COUNT_HIGH_BYTE, 32'h12);
  endtask : scen_latch

  // Divide by eight: about five counts in forty reference periods, match 3 passed
  task scen_divide;
    logic [31:0] rd;
    logic        er;
    wr(IDX_TOP_LOW, 8'hFF);
    wr(IDX_TOP_HIGH, 8'hFF);
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_COUNT_HIGH_BYTE, 8'h00);
    wr(IDX_PRESCALE_CONTROL, 8'h03);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    repeat (640) @(posedge sys_clk_i);
    apb(1'b0, {IDX_COUNT_LOW, 2'b00}, 8'h00, rd, er);
    check({31'h0, rd[7:0] >= 8'h04 && rd[7:0] <= 8'h06}, 32'h1);
    rdchk(IDX_IRQ_FLAG_REG, 32'h2);
    wr(IDX_IRQ_FLAG_REG, 8'h03);
    rdchk(IDX_IRQ_FLAG_REG, 32'h0);
  endtask : scen_divide

  // Top 0 thins wrap events to one in three; match above top stays silent
  task scen_events;
    int ev;
    int mev;
    ev  = 0;
    mev = 0;
    wr(IDX_TOP_LOW, 8'h00);
    wr(IDX_TOP_HIGH, 8'h00);
    wr(IDX_MATCH_LOW, 8'h05);
    wr(IDX_MATCH_HIGH, 8'h00);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    wr(IDX_COUNT_LOW, 8'h00);
    wr(IDX_COUNT_HIGH_BYTE, 8'h00);
    wr(IDX_PRESCALE_CONTROL, 8'h01);
    wait_bits(IDX_SYNC_STATE, 8'h01, 8'h00);
    // Top 0 first, then top 1 thins to one in two
    for (int t = 0; t < 2; t++) begin
      if (t == 1) begin
        wr(IDX_TOP_LOW, 8'h01);
        wr(IDX_TOP_HIGH, 8'h00);
      end
      ev  = 0;
      mev = 0;
      repeat (160) @(posedge sys_clk_i);
      repeat (480) begin
        @(posedge sys_clk_i);
        if (wrap_event_o === 1'b1) ev++;
        if (match_event_o === 1'b1) mev++;
      end
      check({31'h0, (t == 0) ? (ev >= 9 && ev <= 11) : (ev >= 6 && ev <= 9)}, 32'h1);
      check(32'(mev), 32'h0);
    end
    rdchk(IDX_IRQ_FLAG_REG, 32'h1);
  endtask : scen_events

  // Main sequence
  initial begin
    miscompares  = 0;
    total_checks = 0;
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    scen_reset();
    scen_prescale();
    scen_wrap_match();
    scen_flags();
    scen_latch();
    scen_divide();
    scen_events();
    complete_run();
  end
endmodule : tb_low_power_real_time_counter
`default_nettype wire
